//--- src/swrd_top.v
// Purpose: Wake detect mode register C with AXI4-Lite slave and interrupt
// Assumes: One clock, synchronous active-low reset, request inputs synchronous
// Notes: Mode 0x0, clear 0x4, status 0x8 (write 1 clears), mask 0xC
`timescale 1ns/10ps
`include "swrd_consts.vh"
module swrd_top (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [3:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [3:0]  s_axi_araddr,
  // AXI4-Lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // Wake request sources
  input  wire        rtc_request,
  input  wire        ext_irq_six,
  input  wire        ext_irq_seven,
  input  wire        remote_rx1_request,
  // Standby release and interrupt
  output reg         standby_release_q,
  output reg         irq_q
);
  // Per byte: mode [6:4], enable [0]; byte 0 clock, 1 irq6, 2 irq7, 3 rx1
  reg  [11:0] mode_q;
  reg  [3:0]  enable_q;
  reg  [3:0]  status_q;
  reg  [3:0]  mask_q;
  reg  [3:0]  aw_addr_q;
  reg         aw_have_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         w_have_q;
  wire [3:0]  pending;
  wire [7:0]  edges;
  wire [3:0]  req_vec = {remote_rx1_request, ext_irq_seven, ext_irq_six, rtc_request};
  wire        do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire [4:0]  clr_code = w_data_q[4:0];
  reg  [3:0]  clear_vec;
  reg  [3:0]  pend_d;
  reg  [31:0] mode_word;
  integer     i;
  integer     j;

  // Clear register decode, one channel per code
  always @* begin
    clear_vec = 4'h0;
    if (do_write && aw_addr_q == `SWRD_OFS_CLEAR && w_strb_q[0]) begin
      case (clr_code)
        `SWRD_CLR_RTC:  clear_vec = 4'h1;
        `SWRD_CLR_IRQ6: clear_vec = 4'h2;
        `SWRD_CLR_IRQ7: clear_vec = 4'h4;
        `SWRD_CLR_RX1:  clear_vec = 4'h8;
        default:        clear_vec = 4'h0; // Other channels live elsewhere
      endcase
    end
  end

  // Four identical channels
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      swrd_channel u_ch (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .mode      (mode_q[3*g +: 3]),
        .enable    (enable_q[g]),
        .req_in    (req_vec[g]),
        .clear     (clear_vec[g]),
        .pending_q (pending[g]),
        .edge_q    (edges[2*g +: 2])
      );
    end
  endgenerate

  // Read view of the mode register; byte top bit 7 zero, bit 1 reads 0
  always @* begin
    mode_word = 32'h0000_0000;
    for (i = 0; i < 4; i = i + 1) begin
      mode_word[8*i + `SWRD_MODE_LSB +: 3] = mode_q[3*i +: 3];
      mode_word[8*i + `SWRD_EDGE_LSB +: 2] = edges[2*i +: 2];
      mode_word[8*i + `SWRD_EN_BIT]        = enable_q[i];
    end
  end

  // Pending flags set sticky status bits only where not already set
  always @* begin
    pend_d = pending & ~status_q;
  end

  // Write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SWRD_RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 4'h0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q[1:0] == 2'h0) ? `SWRD_RESP_OKAY : `SWRD_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register file; mode and enable written as software orders them
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_q   <= {4{`SWRD_MODE_FALL}};
      enable_q <= 4'h0;
      status_q <= 4'h0;
      mask_q   <= 4'h0;
    end else begin
      // A bit not yet set beats a same-cycle write-one clear; a set bit whose pending flag stays high clears for one cycle
      status_q <= status_q | pend_d;
      if (do_write) begin
        case (aw_addr_q)
          `SWRD_OFS_MODE: begin
            // Trusts software to stage mode before enable; no interlock
            for (j = 0; j < 4; j = j + 1) begin
              if (w_strb_q[j]) begin
                mode_q[3*j +: 3] <= w_data_q[8*j + `SWRD_MODE_LSB +: 3];
                enable_q[j]      <= w_data_q[8*j + `SWRD_EN_BIT];
              end
            end
          end
          `SWRD_OFS_STATUS: if (w_strb_q[0]) status_q <= (status_q & ~w_data_q[3:0]) | pend_d;
          `SWRD_OFS_MASK:   if (w_strb_q[0]) mask_q <= w_data_q[3:0];
          default: ;
        endcase
      end
    end
  end

  // Read channel, one cycle latency
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SWRD_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `SWRD_RESP_OKAY;
        case (s_axi_araddr)
          `SWRD_OFS_MODE:   s_axi_rdata <= mode_word;
          `SWRD_OFS_CLEAR:  s_axi_rdata <= 32'h0000_0000; // Write-only
          `SWRD_OFS_STATUS: s_axi_rdata <= {28'h000_0000, status_q};
          `SWRD_OFS_MASK:   s_axi_rdata <= {28'h000_0000, mask_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SWRD_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Outputs registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      standby_release_q <= 1'b0;
      irq_q             <= 1'b0;
    end else begin
      standby_release_q <= |pending;
      irq_q             <= |(status_q & mask_q);
    end
  end
endmodule // swrd_top

//--- inc/swrd_consts.vh
// Purpose: Constants for the standby wake request detector
// Assumes: Included by bare name from the design files
// Notes: Offsets are byte addresses on the AXI4-Lite register bus
`ifndef SWRD_CONSTS_VH
`define SWRD_CONSTS_VH

// Register byte offsets
`define SWRD_OFS_MODE    4'h0
`define SWRD_OFS_CLEAR   4'h4
`define SWRD_OFS_STATUS  4'h8
`define SWRD_OFS_MASK    4'hC

// Detection mode codes
`define SWRD_MODE_LOW    3'h0
`define SWRD_MODE_HIGH   3'h1
`define SWRD_MODE_FALL   3'h2
`define SWRD_MODE_RISE   3'h3
`define SWRD_MODE_BOTH   3'h4

// Edge status codes
`define SWRD_EDGE_NONE   2'h0
`define SWRD_EDGE_RISE   2'h1
`define SWRD_EDGE_FALL   2'h2
`define SWRD_EDGE_BOTH   2'h3

// Clear register codes for the four channels
`define SWRD_CLR_RTC     5'h08
`define SWRD_CLR_IRQ6    5'h09
`define SWRD_CLR_IRQ7    5'h0A
`define SWRD_CLR_RX1     5'h0B

// Field positions within each byte
`define SWRD_MODE_LSB    4
`define SWRD_EDGE_LSB    2
`define SWRD_EN_BIT      0
`define SWRD_UNDEF_BIT   1

// AXI responses
`define SWRD_RESP_OKAY   2'h0
`define SWRD_RESP_SLVERR 2'h2

`endif

//--- src/swrd_channel.v
// Purpose: One wake request channel: detection, pending flag and edge record
// Assumes: Request input synchronous to aclk
// Notes: Pending holds until cleared; set wins over clear
`timescale 1ns/10ps
`include "swrd_consts.vh"
module swrd_channel (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Configuration
  input  wire [2:0] mode,
  input  wire       enable,
  // Request and clear
  input  wire       req_in,
  input  wire       clear,
  // State
  output reg        pending_q,
  output reg  [1:0] edge_q
);
  reg        prev_q;
  wire       rise = req_in & ~prev_q;
  wire       fall = ~req_in & prev_q;
  reg        hit;
  reg  [1:0] seen;

  // Match the request against the selected mode
  always @* begin
    hit  = 1'b0;
    seen = `SWRD_EDGE_NONE;
    case (mode)
      `SWRD_MODE_LOW:  hit = ~req_in;
      `SWRD_MODE_HIGH: hit = req_in;
      `SWRD_MODE_FALL: hit = fall;
      `SWRD_MODE_RISE: hit = rise;
      `SWRD_MODE_BOTH: begin
        hit  = rise | fall;
        seen = rise ? `SWRD_EDGE_RISE : `SWRD_EDGE_FALL;
      end
      default: hit = 1'b0;
    endcase
  end

  // Pending flag and edge record; a new wake beats a same-cycle clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_q    <= 1'b0;
      pending_q <= 1'b0;
      edge_q    <= `SWRD_EDGE_NONE;
    end else begin
      prev_q <= req_in;
      if (hit && enable) begin
        pending_q <= 1'b1;
        if (mode == `SWRD_MODE_BOTH) begin
          edge_q <= pending_q ? `SWRD_EDGE_BOTH | edge_q : seen;
        end
      end else if (clear) begin
        pending_q <= 1'b0;
        edge_q    <= `SWRD_EDGE_NONE;
      end
    end
  end
endmodule // swrd_channel

//--- tb/swrd_src.sv
// Purpose: Far-side wake request sources
// Assumes: Levels chosen by the bench
// Notes: Registered, so lines move just after an edge
`timescale 1ns/10ps
module swrd_src (
  // Clock and levels
  input  wire       aclk,
  input  wire [3:0] lvl,
  // Request lines
  output reg        rtc_request,
  output reg        ext_irq_six,
  output reg        ext_irq_seven,
  output reg        remote_rx1_request
);
  // Known levels before the first edge
  initial {remote_rx1_request, ext_irq_seven, ext_irq_six, rtc_request} = 4'h0;
  // Synchronous to the system clock
  always @(posedge aclk) begin
    {remote_rx1_request, ext_irq_seven, ext_irq_six, rtc_request} <= lvl;
  end
endmodule // swrd_src

//--- tb/swrd_top_props.sv
// Purpose: Port checks for the wake request detector
// Assumes: One clock, synchronous active-low reset
// Notes: Keeps the taken read address to judge read data
`timescale 1ns/10ps
module swrd_top_props (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus and outputs
  input wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire        s_axi_rvalid, s_axi_rready, standby_release_q, irq_q,
  input wire [3:0]  s_axi_araddr,
  input wire [31:0] s_axi_rdata
);
  reg [3:0] ra_q;
  // Address of the read under way
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("rdata moved early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid) else $error("late bvalid");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late rvalid");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_mode_fixed: assert property (s_axi_rvalid && ra_q == 4'h0 |->
    (s_axi_rdata & 32'h8282_8282) == 32'h0000_0000) else $error("fixed bits wrong");
  a_edge_both: assert property (s_axi_rvalid && ra_q == 4'h0 && s_axi_rdata[11:10] != 2'h0
    |-> s_axi_rdata[14:12] == 3'h4) else $error("edge outside both mode");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !standby_release_q
    && !irq_q && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs not reset");
endmodule // swrd_top_props
bind swrd_top swrd_top_props chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .standby_release_q, .irq_q, .s_axi_araddr, .s_axi_rdata);

//--- tb/testbench.sv
// Purpose: Self-checking bench for the wake request detector
// Assumes: Bus tasks start just after a rising edge
// Notes: Detection latency is fixed, so waits are fixed counts
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  typedef struct {int ch; bit [2:0] md; bit idle; bit act; bit wake; bit [1:0] eg;} swrd_row_t;
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready;
  reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, lvl;
  reg  [31:0] s_axi_wdata, mreg, d;
  reg  [1:0]  resp;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_q;
  wire        standby_release_q, rtc_request, ext_irq_six, ext_irq_seven, remote_rx1_request;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int         failures, checked;
  swrd_row_t  rows [7] = '{'{0, 3'h2, 1, 0, 1, 2'h0}, '{3, 3'h3, 0, 1, 1, 2'h0},
    '{1, 3'h0, 1, 0, 1, 2'h0}, '{2, 3'h1, 0, 1, 1, 2'h0}, '{1, 3'h4, 0, 1, 1, 2'h1},
    '{2, 3'h4, 1, 0, 1, 2'h2}, '{1, 3'h5, 0, 1, 0, 2'h0}};
  swrd_top dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .rtc_request, .ext_irq_six, .ext_irq_seven, .remote_rx1_request,
    .standby_release_q, .irq_q);
  swrd_src src (.aclk, .lvl, .rtc_request, .ext_irq_six, .ext_irq_seven, .remote_rx1_request);
  // Write: address and data offered together, each released when taken
  task automatic wr(input [3:0] a, input [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp; // Response ready stays high between writes
  endtask
  task automatic rd(input [3:0] a, output [31:0] v);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp; // Read ready stays high between reads
  endtask
  task automatic setm(input int ch, input [2:0] md, input bit en);
    mreg[8*ch+:8] = {1'b0, md, 3'h0, en};
    wr(4'h0, mreg);
  endtask
  // Disable before the idle return so it cannot re-arm the channel
  task automatic quiet(input int ch, input [2:0] md, input bit idle);
    setm(ch, md, 0);
    lvl[ch] <= idle;
    repeat (3) @(posedge aclk);
    wr(4'h4, 32'(8 + ch));
    repeat (2) @(posedge aclk);
    `CHK(standby_release_q, 1'b0)
    rd(4'h0, d);
    `CHK(d[8*ch+2+:2], 2'h0)
  endtask
  task end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    #100000;
    failures++;
    end_sim;
  end
  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lvl} = 44'h0;
    s_axi_wstrb = 4'hF;
    mreg = 32'h3020_2020;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'h0, d);
    `CHK(d, 32'h2020_2020)
    `CHK(resp, 2'h0)
    foreach (rows[i]) begin
      lvl[rows[i].ch] <= rows[i].idle;
      setm(rows[i].ch, rows[i].md, 0);
      setm(rows[i].ch, rows[i].md, 1);
      `CHK(standby_release_q, 1'b0)
      lvl[rows[i].ch] <= rows[i].act;
      repeat (5) @(posedge aclk);
      `CHK(standby_release_q, rows[i].wake)
      rd(4'h0, d);
      `CHK(d[8*rows[i].ch+2+:2], rows[i].eg)
      quiet(rows[i].ch, rows[i].md, rows[i].idle);
      $display("row %0d done", i);
    end
    // Rise then fall in both-edges mode
    setm(1, 3'h4, 0);
    setm(1, 3'h4, 1);
    lvl[1] <= 1'b1;
    repeat (3) @(posedge aclk);
    lvl[1] <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(4'h0, d);
    `CHK(d[11:10], 2'h3)
    quiet(1, 3'h4, 0);
    // Disabled channel must not wake
    lvl[3] <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK(standby_release_q, 1'b0)
    lvl[3] <= 1'b0;
    `CHK(irq_q, 1'b0)
    wr(4'hC, 32'h0000_0002);
    repeat (2) @(posedge aclk);
    `CHK(irq_q, 1'b1)
    rd(4'h8, d);
    `CHK(d, 32'h0000_000F)
    rd(4'hC, d);
    `CHK(d, 32'h0000_0002)
    wr(4'h8, 32'h0000_000F);
    repeat (2) @(posedge aclk);
    `CHK(irq_q, 1'b0)
    rd(4'h8, d);
    `CHK(d, 32'h0000_0000)
    wr(4'h2, 32'h0000_0000);
    `CHK(resp, 2'h2)
    rd(4'h2, d);
    `CHK(resp, 2'h2)
    `CHK(d, 32'h0000_0000)
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'h0, d);
    `CHK(d, 32'h2020_2020)
    $display("hand tests done");
    end_sim;
  end
endmodule // testbench
